// ==== src/dcev_top.sv ====
/*
  dma channel event control: decides when a channel transfer starts or
  is aborted, from irq broadcasts, software force/abort and pattern match.
  assumes a classic wishbone master, one irq number per cycle on irq_i,
  and a channel engine that reacts to the one-cycle start/abort pulses.
*/
// Implementation choices: the address map and the Wishbone slave port.
`include "dcev_cfg.svh"

// Functional notes
// - bits 23:16 hold abort irq; with bit 3 set its match aborts transfer and sets abort flag.
// - bits 15:8 hold start irq number 0 to 255.
// - writing one to bit 7 starts a transfer at once; reads zero.
// - writing one to bit 6 aborts the transfer; reads zero.
// - bit 5 set lets pattern match abort and clear channel enable.
// - bit 4 set lets start irq match launch one cell transfer.
// - bit 3 set lets abort irq match abort the transfer.
// - bits 31:24 and 2:0 read zero and ignore writes.
module dcev_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // event sources
  input wire dcev_pkg::dcev_irq_t irq_i,
  input wire logic pattern_match_i,
  // channel engine and interrupt
  input wire logic channel_enable_set_i,
  output logic channel_enable_o,
  output logic channel_abort_flag_o,
  output logic cell_start_o,
  output logic transfer_abort_o,
  output logic irq_o
);
  import dcev_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  dcev_cfg_t cfg_reg;
  logic [2:0] stat_reg;
  logic [2:0] mask_reg;
  dcev_bus_t bus_reg;
  logic force_req;
  logic abort_req;
  logic wr_econ;
  logic wr_stat;
  logic wr_mask;
  logic req;
  logic start_hit;
  logic abort_hit;
  logic pat_hit;
  logic do_abort;
  logic do_start;
  logic [31:0] rd_next;

  assign req = wb_cyc_i && wb_stb_i && (bus_reg == DCEV_IDLE);

  // writes land on the edge where the master sees ack high, so a write
  // and its acknowledge are one event; the master still holds the
  // request then, so address and data are those it was acked for
  assign wr_econ = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i
    && (wb_adr_i == `DCEV_OFS_ECON);
  assign wr_stat = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i
    && (wb_adr_i == `DCEV_OFS_STAT);
  assign wr_mask = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i
    && (wb_adr_i == `DCEV_OFS_MASK);

  // ----------------------------------------------------------------
  // bus handshake: ack one cycle after the request, dropped next cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_reg <= DCEV_IDLE;
      wb_ack_o <= 1'b0;
    end else begin
      unique case (bus_reg)
        DCEV_IDLE: begin
          wb_ack_o <= req;
          if (req) begin
            bus_reg <= DCEV_ACK;
          end
        end
        DCEV_ACK: begin
          wb_ack_o <= 1'b0;
          bus_reg <= DCEV_IDLE;
        end
      endcase
    end
  end

  // read mux; unmapped offsets read zero and ack normally
  always_comb begin
    rd_next = 32'h0;
    unique case (wb_adr_i)
      `DCEV_OFS_ECON: begin
        // force/abort read zero, unimplemented bits zero
        rd_next[`DCEV_ABORT_IRQ_HI:`DCEV_ABORT_IRQ_LO] =
          cfg_reg.abort_irq_number;
        rd_next[`DCEV_START_IRQ_HI:`DCEV_START_IRQ_LO] =
          cfg_reg.start_irq_number;
        rd_next[`DCEV_PAT_EN_BIT] = cfg_reg.pattern_abort_enable;
        rd_next[`DCEV_START_EN_BIT] = cfg_reg.start_trigger_enable;
        rd_next[`DCEV_ABORT_EN_BIT] = cfg_reg.abort_trigger_enable;
      end
      `DCEV_OFS_STAT: rd_next[2:0] = stat_reg;
      `DCEV_OFS_MASK: rd_next[2:0] = mask_reg;
      default: rd_next = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= rd_next;
    end
  end

  // ----------------------------------------------------------------
  // event control register, byte lanes honoured
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg.abort_irq_number <= `DCEV_IRQ_RESET;
      cfg_reg.start_irq_number <= `DCEV_IRQ_RESET;
      cfg_reg.pattern_abort_enable <= 1'b0;
      cfg_reg.start_trigger_enable <= 1'b0;
      cfg_reg.abort_trigger_enable <= 1'b0;
    end else if (wr_econ) begin
      if (wb_sel_i[2]) begin
        cfg_reg.abort_irq_number <= wb_dat_i[23:16];
      end
      if (wb_sel_i[1]) begin
        cfg_reg.start_irq_number <= wb_dat_i[15:8];
      end
      if (wb_sel_i[0]) begin
        cfg_reg.pattern_abort_enable <= wb_dat_i[`DCEV_PAT_EN_BIT];
        cfg_reg.start_trigger_enable <= wb_dat_i[`DCEV_START_EN_BIT];
        cfg_reg.abort_trigger_enable <= wb_dat_i[`DCEV_ABORT_EN_BIT];
      end
    end
  end

  // software strobes live only for the write cycle, nothing is stored
  assign force_req = wr_econ && wb_sel_i[0]
    && wb_dat_i[`DCEV_FORCE_BIT];
  assign abort_req = wr_econ && wb_sel_i[0]
    && wb_dat_i[`DCEV_ABORT_BIT];

  // ----------------------------------------------------------------
  // trigger decode: both comparisons in the same cycle
  // ----------------------------------------------------------------
  assign abort_hit = irq_i.valid && cfg_reg.abort_trigger_enable
    && (irq_i.number == cfg_reg.abort_irq_number);
  assign start_hit = irq_i.valid && cfg_reg.start_trigger_enable
    && (irq_i.number == cfg_reg.start_irq_number);
  assign pat_hit = pattern_match_i && cfg_reg.pattern_abort_enable;
  assign do_abort = abort_hit || abort_req || pat_hit;
  // abort masks any start in the same cycle
  assign do_start = (start_hit || force_req) && !do_abort;

  // one-cycle pulses to the channel engine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cell_start_o <= 1'b0;
      transfer_abort_o <= 1'b0;
    end else begin
      cell_start_o <= do_start;
      transfer_abort_o <= do_abort;
    end
  end

  // abort flag set by an irq abort; a channel re-enable clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel_abort_flag_o <= 1'b0;
    end else if (abort_hit) begin
      channel_abort_flag_o <= 1'b1;
    end else if (channel_enable_set_i) begin
      channel_abort_flag_o <= 1'b0;
    end
  end

  // pattern abort drops the enable; clear wins over a same-cycle set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel_enable_o <= 1'b0;
    end else if (pat_hit) begin
      channel_enable_o <= 1'b0;
    end else if (channel_enable_set_i) begin
      channel_enable_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // interrupt: sticky status, write one to clear, set wins
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_reg <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_stat && wb_sel_i[0] && wb_dat_i[i]) begin
          stat_reg[i] <= 1'b0;
        end
      end
      if (do_start) begin
        stat_reg[`DCEV_ST_START] <= 1'b1;
      end
      if (do_abort) begin
        stat_reg[`DCEV_ST_ABORT] <= 1'b1;
      end
      if (pat_hit) begin
        stat_reg[`DCEV_ST_PAT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_reg <= 3'h0;
    end else if (wr_mask && wb_sel_i[0]) begin
      mask_reg <= wb_dat_i[2:0];
    end
  end

  // registered, so it lags a status change by one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(stat_reg & mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_abort_irq;
    irq_i.valid && cfg_reg.abort_trigger_enable
      && irq_i.number == cfg_reg.abort_irq_number;
  endsequence

  chk_irq_abort_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    s_abort_irq |=> transfer_abort_o && channel_abort_flag_o)
    else $error("abort irq did not abort");
  chk_start_irq_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    start_hit && !do_abort |=> cell_start_o)
    else $error("start irq did not start");
  chk_force_start: assert property (@(posedge clk_i) disable iff (rst_i)
    force_req && !do_abort |=> cell_start_o)
    else $error("force did not start");
  chk_soft_abort: assert property (@(posedge clk_i) disable iff (rst_i)
    abort_req |=> transfer_abort_o)
    else $error("soft abort lost");
  chk_pattern_abort: assert property (@(posedge clk_i) disable iff (rst_i)
    pattern_match_i && cfg_reg.pattern_abort_enable
      |=> !channel_enable_o && transfer_abort_o)
    else $error("pattern abort failed");
  chk_start_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
    !cfg_reg.start_trigger_enable && !force_req |=> !cell_start_o)
    else $error("start while disabled");
  chk_econ_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_we_i && wb_adr_i == `DCEV_OFS_ECON
      |=> wb_ack_o && wb_dat_o[31:24] == 8'h0
      && wb_dat_o[7:6] == 2'h0 && wb_dat_o[2:0] == 3'h0)
    else $error("reserved bits not zero");
  chk_abort_priority: assert property (@(posedge clk_i) disable iff (rst_i)
    abort_hit && start_hit |=> transfer_abort_o && !cell_start_o)
    else $error("start beat abort");

  // ----------------------------------------------------------------
  // bus, interrupt, pattern and abort flag checks
  // ----------------------------------------------------------------
  // a request taken while idle is answered once, then ack drops
  sequence s_bus_take;
    wb_cyc_i && wb_stb_i && bus_reg == DCEV_IDLE;
  endsequence

  sequence s_bus_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  chk_bus_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    s_bus_take |=> s_bus_answer)
    else $error("bus answer malformed");

  // ack never stands two cycles, so a held request is not taken twice
  chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");

  // pattern match with the enable set records its own status bit
  sequence s_pat_event;
    pattern_match_i && cfg_reg.pattern_abort_enable;
  endsequence

  chk_pat_status: assert property (@(posedge clk_i) disable iff (rst_i)
    s_pat_event |=> stat_reg[`DCEV_ST_PAT])
    else $error("pattern status not set");

  // with its enable clear a pattern match must not abort anything
  chk_pat_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
    pattern_match_i && !cfg_reg.pattern_abort_enable && !abort_hit
      && !abort_req |=> !transfer_abort_o)
    else $error("pattern aborted while disabled");

  // the abort flag only ever rises after an irq abort
  chk_flag_source: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(channel_abort_flag_o) |-> $past(abort_hit))
    else $error("abort flag set without irq abort");

  // a channel re-enable clears the flag unless an abort lands with it
  chk_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    channel_enable_set_i && !abort_hit |=> !channel_abort_flag_o)
    else $error("abort flag not cleared");

  // interrupt line follows the masked status one cycle later
  chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> irq_o == $past(|(stat_reg & mask_reg)))
    else $error("interrupt level wrong");

  // status bits are sticky: only a write of one clears them
  for (genvar g = 0; g < 3; g++) begin : g_sticky
    chk_stat_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
      stat_reg[g] && !(wr_stat && wb_sel_i[0] && wb_dat_i[g])
        |=> stat_reg[g])
      else $error("status bit lost");
  end
endmodule

// ==== src/dcev_cfg.svh ====
/*
  constants for the dma channel event control block: register offsets,
  field positions and reset values.
  assumes inclusion by bare name from the design file.
*/
`ifndef DCEV_CFG_SVH
`define DCEV_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DCEV_OFS_ECON 4'h0
`define DCEV_OFS_STAT 4'h4
`define DCEV_OFS_MASK 4'h8

// ----------------------------------------------------------------
// event control fields
// ----------------------------------------------------------------
`define DCEV_ABORT_IRQ_HI 23
`define DCEV_ABORT_IRQ_LO 16
`define DCEV_START_IRQ_HI 15
`define DCEV_START_IRQ_LO 8
`define DCEV_FORCE_BIT 7
`define DCEV_ABORT_BIT 6
`define DCEV_PAT_EN_BIT 5
`define DCEV_START_EN_BIT 4
`define DCEV_ABORT_EN_BIT 3
`define DCEV_IRQ_RESET 8'hff

// ----------------------------------------------------------------
// status and mask bit positions
// ----------------------------------------------------------------
`define DCEV_ST_START 0
`define DCEV_ST_ABORT 1
`define DCEV_ST_PAT 2

`endif

// ==== src/dcev_pkg.sv ====
/*
  types for the dma channel event control block.
  assumes the cfg header sits on the include path.
*/
package dcev_pkg;
  // configuration held in the event control register
  typedef struct packed {
    logic [7:0] abort_irq_number;
    logic [7:0] start_irq_number;
    logic pattern_abort_enable;
    logic start_trigger_enable;
    logic abort_trigger_enable;
  } dcev_cfg_t;

  // interrupt request broadcast from the interrupt system
  typedef struct packed {
    logic valid;
    logic [7:0] number;
  } dcev_irq_t;

  // bus slave handshake state
  typedef enum logic [0:0] {
    DCEV_IDLE,
    DCEV_ACK
  } dcev_bus_t;
endpackage

// ==== bench/dcev_irq_model.sv ====
/*
  irq source model: broadcasts one irq number per cycle when asked.
  assumes the bench drives req_i and num_i just after the rising edge.
*/
module dcev_irq_model (
  // clock and request from the bench
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [7:0] num_i,
  // broadcast to the block
  output dcev_pkg::dcev_irq_t irq_o
);
  import dcev_pkg::*;
  initial irq_o = '0;
  // idle number flips each cycle so a stale value never passes for valid
  always @(posedge clk_i) begin
    irq_o.valid <= req_i;
    irq_o.number <= req_i ? num_i : ~irq_o.number;
  end
endmodule

// ==== bench/testbench.sv ====
/*
  self-checking bench for the dma channel event control block.
  assumes the block's wishbone slave acks each request once.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dcev_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, pat = 0;
  logic en_set = 0, req = 0, ack, chan_en, abort_flag, cell_start;
  logic xfer_abort, irq_out;
  logic [3:0] adr = 0, sel = 0;
  logic [7:0] num = 0;
  logic [31:0] wdat = 0, rdat;
  dcev_irq_t irq;
  int fail_count = 0, checks_done = 0, cycles = 0, n_start = 0, n_abort = 0;

  dcev_irq_model dcev_irq_model_inst (.clk_i(clk_i), .req_i(req),
    .num_i(num), .irq_o(irq));
  dcev_top dcev_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_i(irq),
    .pattern_match_i(pat), .channel_enable_set_i(en_set),
    .channel_enable_o(chan_en), .channel_abort_flag_o(abort_flag),
    .cell_start_o(cell_start), .transfer_abort_o(xfer_abort),
    .irq_o(irq_out));

  // ----------------------------------------------------------------
  // clock, pulse counting, timeout
  // ----------------------------------------------------------------
  always #10 clk_i = ~clk_i;
  // counting pulses keeps checks free of exact launch timing
  always @(posedge clk_i) begin
    cycles++;
    if (cell_start === 1'b1) n_start++;
    if (xfer_abort === 1'b1) n_abort++;
    if (cycles == 5000) begin
      fail_count++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  // one classic cycle; wait ends only on ack or the timeout
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    if (!w) wdat = rdat;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e);
    bus(0, a, 32'h0);
    chk("read", e, wdat);
  endtask
  task automatic send(logic [7:0] n);
    @(posedge clk_i);
    req <= 1;
    num <= n;
    @(posedge clk_i);
    req <= 0;
  endtask
  task automatic settle(int s, int a);
    repeat (4) @(posedge clk_i);
    chk("starts", s, n_start);
    chk("aborts", a, n_abort);
    n_start = 0;
    n_abort = 0;
  endtask
  task automatic pulse_set();
    @(posedge clk_i);
    en_set <= 1;
    @(posedge clk_i);
    en_set <= 0;
  endtask
  task automatic pulse_pat();
    @(posedge clk_i);
    pat <= 1;
    @(posedge clk_i);
    pat <= 0;
  endtask
  task automatic conclude();
    if (fail_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    rd(4'h0, 32'h00ffff00);
    rd(4'hc, 32'h0);
    bus(1, 4'h0, 32'hff2211ff);
    settle(0, 1);
    rd(4'h0, 32'h00221138);
    bus(1, 4'h4, 32'h7);
    bus(1, 4'h8, 32'h7);
    send(8'h11);
    settle(1, 0);
    send(8'h22);
    settle(0, 1);
    chk("abort flag", 1, abort_flag);
    pulse_set();
    repeat (2) @(posedge clk_i);
    chk("enable", 1, chan_en);
    pulse_pat();
    settle(0, 1);
    chk("enable", 0, chan_en);
    rd(4'h4, 32'h7);
    chk("irq", 1, irq_out);
    bus(1, 4'h4, 32'h7);
    repeat (2) @(posedge clk_i);
    chk("irq", 0, irq_out);
    bus(1, 4'h8, 32'h0);
    bus(1, 4'h0, 32'h00221100);
    pulse_set();
    send(8'h11);
    send(8'h22);
    pulse_pat();
    settle(0, 0);
    chk("enable", 1, chan_en);
    chk("irq", 0, irq_out);
    bus(1, 4'h0, 32'h00000080);
    settle(1, 0);
    bus(1, 4'h0, 32'h00000040);
    settle(0, 1);
    bus(1, 4'h0, 32'h00333318);
    send(8'h33);
    settle(0, 1);
    bus(1, 4'h0, 32'h00ff0010);
    send(8'h00);
    settle(1, 0);
    rd(4'h4, 32'h3);
    bus(1, 4'h8, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("irq", 1, irq_out);
    bus(1, 4'h4, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("irq", 0, irq_out);
    conclude();
  end
endmodule
